/* File: hbp_cfg.svh */
// register offsets, field positions and reset values of the host bus port
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH
`define HBP_OFF_CHIPCFG 8'h08
`define HBP_OFF_MACL 8'h10
`define HBP_OFF_MACM 8'h12
`define HBP_OFF_MACH 8'h14
`define HBP_OFF_BUSCTL 8'h20
`define HBP_OFF_HSR 8'h7c
`define HBP_OFF_HBC 8'h7e
`define HBP_OFF_QCR 8'h82
`define HBP_OFF_FDPR 8'h86
`define HBP_OFF_IRQST 8'h92
`define HBP_OFF_FCTR 8'h9c
`define HBP_OFF_QDATA 8'hc0
`define HBP_RST_BUSCTL 16'h0000
`define HBP_RST_WORD 16'h0000
`define HBP_BIT_SWAP 0
`define HBP_BIT_RXIRQ 13
`define HBP_BIT_BURST 3
`define HBP_BIT_AUTOINC 14
`define HBP_LEN_W 12
`endif

/* File: hbp_pkg.sv */
// types shared by the host bus port
package hbp_pkg;
	typedef enum logic {HBP_BUS8, HBP_BUS16} hbp_bus_type;
	typedef enum logic [1:0] {HBP_Q_IDLE, HBP_Q_DUMMY, HBP_Q_DATA} hbp_qstate_type;
endpackage

/* File: hbp_rxq.sv */
// receive frame queue: word store with per-frame descriptors
`timescale 1ns/10ps
`default_nettype none
`include "hbp_cfg.svh"
module hbp_frame_store #(
	parameter int AW = 10,
	parameter int FW = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	input wire logic [15:0] in_word,
	input wire logic in_end,
	input wire logic [15:0] in_status,
	input wire logic [`HBP_LEN_W-1:0] in_len,
	output logic in_ready,
	output logic frame_done,
	input wire logic adv,
	input wire logic release_frame,
	input wire logic [FW-1:0] sel,
	output logic [15:0] q_word,
	output logic [15:0] sel_status,
	output logic [`HBP_LEN_W-1:0] sel_len,
	output logic sel_valid,
	output logic [FW-1:0] head,
	output logic [FW:0] count
);
	logic [15:0] mem [2**AW];
	logic [15:0] hdr_st [2**FW];
	logic [`HBP_LEN_W-1:0] hdr_ln [2**FW];
	logic [AW-1:0] hdr_nx [2**FW];
	logic [AW-1:0] wr_ptr_reg, rd_ptr_reg, wr_ptr_next, rd_ptr_next;
	logic [FW-1:0] tail_reg, head_reg;
	logic [FW:0] count_reg;
	logic ready_reg;
	wire logic accept = in_valid & ready_reg;
	wire logic done = accept & in_end;
	wire logic rel = release_frame & (count_reg != '0);
	wire logic [AW-1:0] step = wr_ptr_reg + 1'b1;
	// frames end on a double-word boundary so the host padding reads land
	wire logic [AW-1:0] padded = step + {{(AW-1){1'b0}}, step[0]};
	wire logic [AW-1:0] used = wr_ptr_reg - rd_ptr_reg;
	wire logic [FW-1:0] rel_idx = sel - head_reg;
	assign wr_ptr_next = accept ? (in_end ? padded : step) : wr_ptr_reg;
	assign rd_ptr_next = rel ? hdr_nx[head_reg] :
		(adv ? rd_ptr_reg + 1'b1 : rd_ptr_reg);
	assign in_ready = ready_reg;
	assign frame_done = done;
	assign q_word = mem[rd_ptr_reg];
	assign sel_status = hdr_st[sel];
	assign sel_len = hdr_ln[sel];
	assign sel_valid = {1'b0, rel_idx} < count_reg;
	assign head = head_reg;
	assign count = count_reg;
	always_ff @(posedge clk) begin
		if (accept) begin
			mem[wr_ptr_reg] <= in_word;
		end
		if (done) begin
			hdr_st[tail_reg] <= in_status;
			hdr_ln[tail_reg] <= in_len;
			hdr_nx[tail_reg] <= padded;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			tail_reg <= '0;
			head_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			tail_reg <= tail_reg + FW'(done);
			head_reg <= head_reg + FW'(rel);
			count_reg <= count_reg + (FW+1)'(done) - (FW+1)'(rel);
			// margin covers the cycle of lag in the registered ready
			ready_reg <= (used < AW'(2**AW - 4)) &&
				(count_reg < (FW+1)'(2**FW - 1));
		end
	end
endmodule
`default_nettype wire

/* File: hbp_host_port.sv */
// host parallel register port with receive frame queue readout
// How it works
// - 8-bit mode: command phase takes a byte address from the low bus lines.
// - 8-bit mode: data phase moves register bytes on the low bus lines.
// - 16-bit mode: address comes from lines 7..2, lines 1..0 ignored.
// - 16-bit mode: lines 15..12 carry byte-lane enables, one or two bytes.
// - 16-bit mode: data phase moves a whole word on all sixteen lines.
// - 16-bit mode: a control bit swaps byte order for big-endian hosts.
// - first queue read of every burst returns a dummy unit.
// - clearing the receive status bit refreshes the frame count register.
// - reading the frame count loads header status and length of first frame.
// - reading both header registers advances them to the next frame.
// - chip configuration is a read-only word at 0x08.
// - station address sits in three words at 0x10, 0x12, 0x14.
// - on-chip bus control word at 0x20 resets to zero.
// - receive status is bit 13 of the status word, cleared by writing one.
// - frame count upper byte holds frames queued when the receive status is cleared.
// - queue control bit 3 opens a burst access to queue data.
// - pointer bit 14 makes the queue address advance after each word read from queue data.
`timescale 1ns/10ps
`default_nettype none
`include "hbp_cfg.svh"
module hbp_host_port #(
	parameter logic [15:0] CHIP_CFG = 16'h0a5a, // arbitrary value
	parameter int AW = 10,
	parameter int FW = 4
) (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire hbp_pkg::hbp_bus_type BUS_MODE,
	input wire logic CS_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic CMD,
	input wire logic [15:0] SHARED_BUS_IN,
	output logic [15:0] SHARED_BUS_OUT,
	output logic [15:0] SHARED_BUS_OE,
	input wire logic RXF_VALID,
	input wire logic [15:0] RXF_WORD,
	input wire logic RXF_END,
	input wire logic [15:0] RXF_STATUS,
	input wire logic [`HBP_LEN_W-1:0] RXF_BYTES,
	output logic RXF_READY,
	output logic RX_EVENT
);
	import hbp_pkg::*;
	logic cs_n_d, rd_n_d, wr_n_d, cmd_d;
	logic [15:0] bus_d, bus_out_reg, mac_reg [3];
	logic bus_oe_reg, ev_reg;
	logic [7:0] addr_reg;
	logic [3:0] be_reg;
	logic [15:0] ctl_reg, hsr_reg, hbc_reg;
	logic [7:0] fct_hi_reg, fct_lo_reg;
	logic rx_irq_reg, burst_reg, autoinc_reg, seen_hsr_reg, seen_hbc_reg;
	logic ld_hdr_reg, phase_reg;
	hbp_qstate_type qst_reg;
	logic [FW-1:0] desc_reg;
	logic [15:0] q_word, sel_status;
	logic [`HBP_LEN_W-1:0] sel_len;
	logic sel_valid, frame_done, in_ready;
	logic [FW-1:0] q_head;
	logic [FW:0] q_count;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] m);
		merge = {m[1] ? nw[15:8] : old[15:8], m[0] ? nw[7:0] : old[7:0]};
	endfunction
	function automatic logic [15:0] swap(input logic [15:0] v,
		input logic en);
		swap = en ? {v[7:0], v[15:8]} : v;
	endfunction

	wire logic bus16 = (BUS_MODE == HBP_BUS16);
	wire logic swap_en = ctl_reg[`HBP_BIT_SWAP];
	wire logic hi_word = (be_reg[3:2] != 2'b00);
	// word offset and lane mask of the current access
	wire logic [7:0] woff = bus16 ? {addr_reg[7:2], hi_word, 1'b0}
		: {addr_reg[7:1], 1'b0};
	wire logic [1:0] lanes = bus16 ? (hi_word ? be_reg[3:2] : be_reg[1:0])
		: (addr_reg[0] ? 2'b10 : 2'b01);
	wire logic wr_end = !cs_n_d && !wr_n_d && WR_N;
	wire logic rd_end = !cs_n_d && !rd_n_d && RD_N && !cmd_d;
	wire logic addr_wr = wr_end && cmd_d;
	wire logic data_wr = wr_end && !cmd_d;
	wire logic [15:0] wdata = bus16 ? swap(bus_d, swap_en)
		: {bus_d[7:0], bus_d[7:0]};
	wire logic wr_irq = data_wr && woff == `HBP_OFF_IRQST;
	wire logic wr_qcr = data_wr && woff == `HBP_OFF_QCR && lanes[0];
	wire logic rx_clr = wr_irq && lanes[1] && wdata[`HBP_BIT_RXIRQ];
	wire logic q_rd = rd_end && woff == `HBP_OFF_QDATA && burst_reg;
	wire logic burst_new = wdata[`HBP_BIT_BURST];
	wire logic burst_open = wr_qcr && burst_new && !burst_reg;
	wire logic burst_close = wr_qcr && !burst_new && burst_reg;
	// a byte-wide host consumes each queue word in two reads
	wire logic word_used = bus16 || phase_reg;
	wire logic q_adv = q_rd && qst_reg == HBP_Q_DATA && word_used
		&& autoinc_reg;
	wire logic both_seen = (seen_hsr_reg || (rd_end && woff == `HBP_OFF_HSR))
		&& (seen_hbc_reg || (rd_end && woff == `HBP_OFF_HBC));
	wire logic [15:0] qdat = (qst_reg == HBP_Q_DATA) ? q_word
		: `HBP_RST_WORD;
	wire logic [15:0] irq_word = 16'(rx_irq_reg) << `HBP_BIT_RXIRQ;
	wire logic [15:0] qcr_word = 16'(burst_reg) << `HBP_BIT_BURST;
	wire logic [15:0] fdpr_word = 16'(autoinc_reg) << `HBP_BIT_AUTOINC;
	logic [15:0] rword;
	always_comb begin
		case (woff)
			`HBP_OFF_CHIPCFG: rword = CHIP_CFG;
			`HBP_OFF_MACL: rword = mac_reg[0];
			`HBP_OFF_MACM: rword = mac_reg[1];
			`HBP_OFF_MACH: rword = mac_reg[2];
			`HBP_OFF_BUSCTL: rword = ctl_reg;
			`HBP_OFF_HSR: rword = hsr_reg;
			`HBP_OFF_HBC: rword = hbc_reg;
			`HBP_OFF_QCR: rword = qcr_word;
			`HBP_OFF_FDPR: rword = fdpr_word;
			`HBP_OFF_IRQST: rword = irq_word;
			`HBP_OFF_FCTR: rword = {fct_hi_reg, fct_lo_reg};
			`HBP_OFF_QDATA: rword = qdat;
			default: rword = `HBP_RST_WORD;
		endcase
	end
	wire logic [15:0] rbyte = phase_reg ? {8'h00, qdat[15:8]}
		: {8'h00, qdat[7:0]};
	wire logic [15:0] rsel8 = (woff == `HBP_OFF_QDATA) ? rbyte
		: (addr_reg[0] ? {8'h00, rword[15:8]} : {8'h00, rword[7:0]});
	wire logic [15:0] rdata = bus16 ? swap(rword, swap_en) : rsel8;

	hbp_frame_store #(.AW(AW), .FW(FW)) i_hbp_frame_store (
		.clk(CLK_SYS),
		.srst(SRST),
		.in_valid(RXF_VALID),
		.in_word(RXF_WORD),
		.in_end(RXF_END),
		.in_status(RXF_STATUS),
		.in_len(RXF_BYTES),
		.in_ready(in_ready),
		.frame_done(frame_done),
		.adv(q_adv),
		.release_frame(burst_close),
		.sel(desc_reg),
		.q_word(q_word),
		.sel_status(sel_status),
		.sel_len(sel_len),
		.sel_valid(sel_valid),
		.head(q_head),
		.count(q_count)
	);

	assign SHARED_BUS_OUT = bus_out_reg;
	assign SHARED_BUS_OE = {16{bus_oe_reg}};
	assign RXF_READY = in_ready;
	assign RX_EVENT = ev_reg;

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			cs_n_d <= 1'b1;
			rd_n_d <= 1'b1;
			wr_n_d <= 1'b1;
			cmd_d <= 1'b0;
			bus_d <= '0;
			bus_out_reg <= '0;
			bus_oe_reg <= 1'b0;
			ev_reg <= 1'b0;
		end else begin
			cs_n_d <= CS_N;
			rd_n_d <= RD_N;
			wr_n_d <= WR_N;
			cmd_d <= CMD;
			bus_d <= SHARED_BUS_IN;
			bus_out_reg <= rdata;
			bus_oe_reg <= !CS_N && !RD_N && !CMD;
			ev_reg <= frame_done;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			addr_reg <= '0;
			be_reg <= '0;
			ctl_reg <= `HBP_RST_BUSCTL;
			for (int i = 0; i < 3; i++) begin
				mac_reg[i] <= `HBP_RST_WORD;
			end
			fct_lo_reg <= '0;
			autoinc_reg <= 1'b0;
		end else begin
			if (addr_wr) begin
				addr_reg <= bus_d[7:0];
				be_reg <= bus_d[15:12];
			end
			if (data_wr) begin
				case (woff)
					`HBP_OFF_MACL: mac_reg[0] <= merge(mac_reg[0], wdata, lanes);
					`HBP_OFF_MACM: mac_reg[1] <= merge(mac_reg[1], wdata, lanes);
					`HBP_OFF_MACH: mac_reg[2] <= merge(mac_reg[2], wdata, lanes);
					`HBP_OFF_BUSCTL: ctl_reg <= merge(ctl_reg, wdata, lanes);
					`HBP_OFF_FCTR: begin
						if (lanes[0]) begin
							fct_lo_reg <= wdata[7:0];
						end
					end
					`HBP_OFF_FDPR: begin
						if (lanes[1]) begin
							autoinc_reg <= wdata[`HBP_BIT_AUTOINC];
						end
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			rx_irq_reg <= 1'b0;
			fct_hi_reg <= '0;
			burst_reg <= 1'b0;
			qst_reg <= HBP_Q_IDLE;
			phase_reg <= 1'b0;
		end else begin
			// a frame landing in the clearing cycle keeps the bit set
			rx_irq_reg <= frame_done || (rx_irq_reg && !rx_clr);
			if (rx_clr) begin
				fct_hi_reg <= 8'(q_count);
			end
			if (wr_qcr) begin
				burst_reg <= burst_new;
			end
			phase_reg <= burst_open ? 1'b0
				: ((q_rd && qst_reg == HBP_Q_DATA && !bus16) ? !phase_reg
				: phase_reg);
			case (qst_reg)
				HBP_Q_IDLE: qst_reg <= burst_open ? HBP_Q_DUMMY : HBP_Q_IDLE;
				HBP_Q_DUMMY: qst_reg <= burst_close ? HBP_Q_IDLE
					: (q_rd ? HBP_Q_DATA : HBP_Q_DUMMY);
				HBP_Q_DATA: qst_reg <= burst_close ? HBP_Q_IDLE : HBP_Q_DATA;
				default: qst_reg <= HBP_Q_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			desc_reg <= '0;
			ld_hdr_reg <= 1'b0;
			seen_hsr_reg <= 1'b0;
			seen_hbc_reg <= 1'b0;
			hsr_reg <= '0;
			hbc_reg <= '0;
		end else begin
			ld_hdr_reg <= 1'b0;
			if (rd_end && woff == `HBP_OFF_FCTR) begin
				desc_reg <= q_head;
				ld_hdr_reg <= 1'b1;
				seen_hsr_reg <= 1'b0;
				seen_hbc_reg <= 1'b0;
			end else if (both_seen) begin
				desc_reg <= desc_reg + 1'b1;
				ld_hdr_reg <= 1'b1;
				seen_hsr_reg <= 1'b0;
				seen_hbc_reg <= 1'b0;
			end else if (rd_end) begin
				seen_hsr_reg <= seen_hsr_reg || woff == `HBP_OFF_HSR;
				seen_hbc_reg <= seen_hbc_reg || woff == `HBP_OFF_HBC;
			end
			if (ld_hdr_reg) begin
				hsr_reg <= sel_valid ? sel_status : `HBP_RST_WORD;
				hbc_reg <= sel_valid ? 16'(sel_len) : `HBP_RST_WORD;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hbp_host_port_properties.sv */
// pin-level assertions for the host bus port
`timescale 1ns/10ps
`default_nettype none
module hbp_port_checker (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire hbp_pkg::hbp_bus_type BUS_MODE,
	input wire logic CS_N,
	input wire logic RD_N,
	input wire logic CMD,
	input wire logic [15:0] SHARED_BUS_OUT,
	input wire logic [15:0] SHARED_BUS_OE,
	input wire logic RXF_VALID,
	input wire logic RXF_END,
	input wire logic RXF_READY,
	input wire logic RX_EVENT
);
	import hbp_pkg::*;
	wire logic took = RXF_VALID && RXF_READY && RXF_END;
	wire logic drive = SHARED_BUS_OE[0];
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	property p_oe_same;
		SHARED_BUS_OE == 16'h0000 || SHARED_BUS_OE == 16'hffff;
	endproperty
	a_oe_same: assert property (p_oe_same) else $error("enables differ");
	// the enable flop samples the pins one edge before it shows
	property p_oe_on; drive |-> $past(!CS_N && !RD_N && !CMD); endproperty
	a_oe_on: assert property (p_oe_on) else $error("drive without read");
	property p_oe_off; RD_N || CS_N || CMD |=> !drive; endproperty
	a_oe_off: assert property (p_oe_off) else $error("drive held");
	property p_byte_hi;
		$stable(BUS_MODE) && BUS_MODE == HBP_BUS8 && drive |->
			SHARED_BUS_OUT[15:8] == 8'h00;
	endproperty
	a_byte_hi: assert property (p_byte_hi) else $error("high byte set");
	property p_ev_one; RX_EVENT |=> !RX_EVENT || $past(took); endproperty
	a_ev_one: assert property (p_ev_one) else $error("event too long");
	property p_ev_cause; RX_EVENT |-> $past(took); endproperty
	a_ev_cause: assert property (p_ev_cause) else $error("stray event");
	property p_ev_due; took |=> RX_EVENT; endproperty
	a_ev_due: assert property (p_ev_due) else $error("event missing");
	// the store is empty after reset, so input must open promptly
	property p_rdy_up; $fell(SRST) |-> ##[0:3] RXF_READY; endproperty
	a_rdy_up: assert property (p_rdy_up) else $error("ready late");
	c_read: cover property (drive && !CMD);
	c_byte: cover property (BUS_MODE == HBP_BUS8 && drive);
	c_event: cover property (RX_EVENT);
endmodule
bind hbp_host_port hbp_port_checker i_hbp_port_checker (.CLK_SYS, .SRST,
	.BUS_MODE, .CS_N, .RD_N, .CMD, .SHARED_BUS_OUT, .SHARED_BUS_OE,
	.RXF_VALID, .RXF_END, .RXF_READY, .RX_EVENT);
`default_nettype wire

/* File: hbp_host_model.sv */
// host processor model driving the shared bus lines
`timescale 1ns/10ps
`default_nettype none
module hbp_host_model (
	input wire logic clk,
	output logic cs_n = 1'b1,
	output logic rd_n = 1'b1,
	output logic wr_n = 1'b1,
	output logic cmd = 1'b0,
	output logic [15:0] bus_drv = 16'h0000,
	input wire logic [15:0] bus_rd,
	input wire logic [15:0] bus_en
);
	// strobes stay low and high two edges each so the port sees both
	task automatic wr(input logic c, input logic [15:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		cmd <= c;
		bus_drv <= d;
		wr_n <= 1'b0;
		repeat (2) @(posedge clk);
		wr_n <= 1'b1;
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		bus_drv <= ~d;
	endtask
	task automatic rd(output logic [15:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		cmd <= 1'b0;
		rd_n <= 1'b0;
		repeat (2) @(posedge clk);
		// taken mid-cycle, away from the edge that updates the output flop
		@(negedge clk);
		d = bus_rd & bus_en;
		@(posedge clk);
		rd_n <= 1'b1;
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: host_bus_rx_frame_port_bench.sv */
// self-checking bench for the host bus port
`timescale 1ns/10ps
`default_nettype none
`include "hbp_cfg.svh"
module host_bus_rx_frame_port_bench;
	import hbp_pkg::*;
	localparam logic [15:0] CFG = 16'h0c3c; // arbitrary value
	logic CLK_SYS = 1'b0;
	logic SRST = 1'b1;
	hbp_bus_type BUS_MODE = HBP_BUS16;
	logic CS_N, RD_N, WR_N, CMD, RXF_READY, RX_EVENT;
	logic RXF_VALID = 1'b0;
	logic RXF_END = 1'b0;
	logic [15:0] host_bus, SHARED_BUS_OUT, SHARED_BUS_OE, v;
	logic [15:0] RXF_WORD = 16'h0000;
	logic [15:0] RXF_STATUS = 16'h0000;
	logic [`HBP_LEN_W-1:0] RXF_BYTES = '0;
	wire logic [15:0] SHARED_BUS_IN = (SHARED_BUS_OE & SHARED_BUS_OUT) |
		(~SHARED_BUS_OE & host_bus);
	int mismatches = 0;
	int checks_done = 0;
	hbp_host_port #(.CHIP_CFG(CFG)) i_hbp_host_port (
		.CLK_SYS(CLK_SYS),
		.SRST(SRST),
		.BUS_MODE(BUS_MODE),
		.CS_N(CS_N),
		.RD_N(RD_N),
		.WR_N(WR_N),
		.CMD(CMD),
		.SHARED_BUS_IN(SHARED_BUS_IN),
		.SHARED_BUS_OUT(SHARED_BUS_OUT),
		.SHARED_BUS_OE(SHARED_BUS_OE),
		.RXF_VALID(RXF_VALID),
		.RXF_WORD(RXF_WORD),
		.RXF_END(RXF_END),
		.RXF_STATUS(RXF_STATUS),
		.RXF_BYTES(RXF_BYTES),
		.RXF_READY(RXF_READY),
		.RX_EVENT(RX_EVENT)
	);
	hbp_host_model i_hbp_host_model (.clk(CLK_SYS), .cs_n(CS_N), .rd_n(RD_N),
		.wr_n(WR_N), .cmd(CMD), .bus_drv(host_bus), .bus_rd(SHARED_BUS_OUT),
		.bus_en(SHARED_BUS_OE));
	initial begin
		forever #10 CLK_SYS = ~CLK_SYS;
	end
	task automatic conclude;
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// lines 1..0 carry junk on purpose: the port must ignore them
	function automatic logic [15:0] a16(input logic [7:0] o);
		return {o[1] ? 4'hc : 4'h3, 4'h0, o[7:2], 2'b11};
	endfunction
	task automatic wreg(input logic [7:0] o, input logic [15:0] d);
		i_hbp_host_model.wr(1'b1, a16(o));
		i_hbp_host_model.wr(1'b0, d);
	endtask
	task automatic rreg(input string nm, input logic [7:0] o, logic [15:0] e);
		i_hbp_host_model.wr(1'b1, a16(o));
		i_hbp_host_model.rd(v);
		chk(nm, e, v);
	endtask
	task automatic push(input logic [15:0] b, st, input int n);
		int k;
		@(posedge CLK_SYS);
		for (int i = 0; i < n; i++) begin
			RXF_VALID <= 1'b1;
			RXF_WORD <= b + 16'(i);
			RXF_END <= (i == n - 1);
			RXF_STATUS <= st;
			RXF_BYTES <= `HBP_LEN_W'(2 * n - 1);
			k = 0;
			do begin
				@(negedge CLK_SYS);
				k++;
			end while (RXF_READY !== 1'b1 && k < 50);
			if (k >= 50) begin
				mismatches++;
				conclude();
			end
			@(posedge CLK_SYS);
		end
		RXF_VALID <= 1'b0;
		k = 0;
		repeat (4) begin
			@(negedge CLK_SYS);
			k += int'(RX_EVENT === 1'b1);
		end
		chk("rx event", 16'h0001, 16'(k));
	endtask
	task automatic t_regs;
		rreg("bus control", 8'h20, 16'h0000);
		wreg(8'h08, ~CFG);
		rreg("chip config", 8'h08, CFG);
		rreg("unmapped", 8'h0a, 16'h0000);
		for (int i = 0; i < 3; i++)
			wreg(8'h10 + 8'(2 * i), 16'h1234 + 16'(i * 'h1111));
		for (int i = 0; i < 3; i++)
			rreg("mac", 8'h10 + 8'(2 * i), 16'h1234 + 16'(i * 'h1111));
	endtask
	task automatic t_lane;
		i_hbp_host_model.wr(1'b1, 16'h1010);
		i_hbp_host_model.wr(1'b0, 16'haabb);
		rreg("low lane", 8'h10, 16'h12bb);
		wreg(8'h20, 16'h0001);
		rreg("swapped", 8'h10, 16'hbb12);
		wreg(8'h20, 16'h0000);
	endtask
	task automatic t_byte;
		@(posedge CLK_SYS);
		BUS_MODE <= HBP_BUS8;
		i_hbp_host_model.wr(1'b1, 16'h5511);
		i_hbp_host_model.rd(v);
		chk("byte read", 16'h0012, v);
		i_hbp_host_model.wr(1'b1, 16'h5514);
		i_hbp_host_model.wr(1'b0, 16'h55ee);
		@(posedge CLK_SYS);
		BUS_MODE <= HBP_BUS16;
		rreg("byte write", 8'h14, 16'h34ee);
	endtask
	task automatic t_queue;
		push(16'h0100, 16'h8001, 3);
		push(16'h0200, 16'h8002, 2);
		wreg(8'h92, 16'h2000);
		rreg("frame count", 8'h9c, 16'h0200);
		rreg("head status", 8'h7c, 16'h8001);
		rreg("head length", 8'h7e, 16'h0005);
		rreg("next status", 8'h7c, 16'h8002);
		rreg("next length", 8'h7e, 16'h0003);
		wreg(8'h86, 16'h4000);
		for (int f = 0; f < 2; f++) begin
			wreg(8'h82, 16'h0008);
			rreg("dummy", 8'hc0, 16'h0000);
			// frame one needs a padding word to reach the double word
			for (int i = 0; i < 4 - 2 * f; i++) begin
				i_hbp_host_model.rd(v);
				if (i < 3 - f)
					chk("queue word", (16'h0100 << f) + 16'(i), v);
			end
			wreg(8'h82, 16'h0000);
		end
		// the count is a snapshot taken when the receive status is cleared
		wreg(8'h92, 16'h2000);
		rreg("count drop", 8'h9c, 16'h0000);
		// byte bus: one dummy byte, then low and high byte of each word
		push(16'h0300, 16'h8003, 1);
		@(posedge CLK_SYS);
		BUS_MODE <= HBP_BUS8;
		i_hbp_host_model.wr(1'b1, 16'h0082);
		i_hbp_host_model.wr(1'b0, 16'h0008);
		i_hbp_host_model.wr(1'b1, 16'h00c0);
		for (int i = 0; i < 5; i++) begin
			i_hbp_host_model.rd(v);
			if (i < 3)
				chk("queue byte", (i == 2) ? 16'h0003 : 16'h0000, v);
		end
		i_hbp_host_model.wr(1'b1, 16'h0082);
		i_hbp_host_model.wr(1'b0, 16'h0000);
		@(posedge CLK_SYS);
		BUS_MODE <= HBP_BUS16;
	endtask
	initial begin
		repeat (5) @(posedge CLK_SYS);
		SRST <= 1'b0;
		t_regs();
		t_lane();
		t_byte();
		t_queue();
		conclude();
	end
endmodule
`default_nettype wire
